// file: fdr_pkg.sv
/*
  Package for the float coprocessor divide-double and round-store datapath.
  Holds register offsets, field positions, rounding constants, step states
  and the memory request bundle. Assumes a 32-bit AHB-Lite register bus and
  a 16-bit word memory port with a one-cycle completion pulse.
*/
package fdr_pkg;

  localparam int FRAC_W = 48;
  localparam int EXP_W = 8;
  localparam int WORD_W = 16;
  localparam int SC_W = 6;
  localparam int ADDR_W = 8;

  // Quotient bits developed by the double precision path
  localparam logic [SC_W-1:0] DIV_BITS_DOUBLE = 6'h30;
  localparam logic [SC_W-1:0] SC_LAST = 6'h01;

  // Rounding and overflow constants
  localparam logic [FRAC_W-1:0] CR_ROUND_SINGLE = 48'h000001000000;
  localparam logic [FRAC_W-1:0] CR_ROUND_DOUBLE = 48'h000000000002;
  localparam logic [FRAC_W-1:0] CR_SIGN_BIT = 48'h800000000000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 48'h000000000000;
  localparam logic [FRAC_W-1:0] FRAC_ONES = 48'hFFFFFFFFFFFF;

  // Exponent constants, excess-128 code
  localparam logic [EXP_W-1:0] EXP_BIAS = 8'h80;
  localparam logic [EXP_W-1:0] EXP_ONE = 8'h01;
  localparam logic [EXP_W-1:0] EXP_MAX = 8'hFF;
  localparam logic [EXP_W-1:0] EXP_ZERO = 8'h00;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ACC_LO = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ACC_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_MEM_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MQ_LO = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MQ_HI = 8'h18;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_EXPONENT_CARRY_FLAG = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_INT = 3;
  localparam int ST_OOR = 4;
  localparam int ST_STATE_LSB = 8;

  // Accumulator high word fields
  localparam int ACC_HI_EXP_LSB = 16;
  localparam int ACC_HI_SIGN = 24;

  // Fetch word index of the third operand word
  localparam logic [1:0] WORD_IDX_THIRD = 2'h2;

  localparam int HTRANS_ACTIVE = 1;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_DIV_DOUBLE = 2'h1,
    OP_STORE_SINGLE = 2'h2,
    OP_STORE_DOUBLE = 2'h3
  } fdr_op_t;

  typedef enum logic [4:0] {
    ST_IDLE,
    ST_DIV_FETCH,
    ST_DIV_EXPONENT,
    ST_DIV_RANGE,
    ST_DIV_FINAL_LOAD,
    ST_DIV_ZERO_CHECK,
    ST_DIV_ZERO_TEST,
    ST_DIV_COUNT_PRESET,
    ST_DIV_ITER,
    ST_DIV_ITER_OOR,
    ST_DIV_COPY,
    ST_OVF_TERM,
    ST_STORE_FIRST,
    ST_STORE_SECOND,
    ST_STORE_ROUND_OVF,
    ST_STORE_RENORM,
    ST_STORE_EXP_OVF,
    ST_STORE_CONST_CLEAR,
    ST_STORE_FIRST_FINISH,
    ST_STORE_SECOND_WORD,
    ST_STORE_THIRD_WORD,
    ST_STORE_FOURTH_WORD,
    ST_STORE_FINAL
  } fdr_state_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } fdr_mem_req_t;

endpackage

// file: fdr_exp_alu.sv
/*
  Exponent-loop adder of the datapath.
  Forms exponent plus one, or the excess-128 quotient exponent difference,
  and flags a carry or out-of-range result. Purely combinational.
*/
`timescale 1ns/10ps
module fdr_exp_alu
  import fdr_pkg::*;
(
  input wire logic [EXP_W-1:0] exp_a,
  input wire logic [EXP_W-1:0] exp_b,
  input wire logic quot_mode,
  output logic [EXP_W-1:0] exp_sum,
  output logic exp_carry
);

  logic [EXP_W+1:0] wide;

  always_comb
  begin
    if (quot_mode)
      wide = {2'h0, exp_a} - {2'h0, exp_b} + {2'h0, EXP_BIAS};
    else
      wide = {2'h0, exp_a} + {2'h0, EXP_ONE};
    exp_sum = wide[EXP_W-1:0];
    exp_carry = wide[EXP_W+1] | wide[EXP_W];
  end

endmodule

// file: fdr_core.sv
/*
  Divide-double entry and round-store datapath of the float coprocessor.
  AHB-Lite slave for commands and accumulator access; 16-bit memory port
  with a request held until a one-cycle done pulse from the memory side.
*/
//
// Overview of operation
// - Double divisor: four words, 48 quotient bits
// - Exponent step: third word, exponent difference, carry
// - Final word into quotient; zero dividend branches
// - Preset count 48, enter matching iteration
// - Quotient bits shift into bit zero
// - Single round: B plus bit-24 constant
// - Single constant loaded when opcode latched
// - First step: clear zero, word one, request
// - Second step: reround, exponent plus one carry
// - Sign overflow branches to overflow step
// - Overflow step waits, loads, sets bit 47
// - No carry: shift right, increment, restart
// - Cleared constant: first word simply rewritten
// - Wait first word, bump address, request
// - Second word, wait, release processor
// - Final step loads rounded fraction to A,B
// - Exponent overflow: B gets complemented constant
// - Then clear constant, restart store
// - Double round constant bit 1 at latch
// - Double store: four words, no release at word two
// - Third word, wait, bump, request
// - Fourth word, wait, release processor
// - Exponents excess-128, carry marks range
// - Overflow end: all ones, interrupt flag
`timescale 1ns/10ps
module fdr_core
  import fdr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output fdr_mem_req_t mem_out,
  input wire logic mem_done,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic cpu_release,
  output logic interrupt_flag
);

  fdr_state_t state_q;
  fdr_op_t op_q;
  logic start_q;
  logic [FRAC_W-1:0] a_q;
  logic [FRAC_W-1:0] b_q;
  logic [FRAC_W-1:0] mq_q;
  logic [FRAC_W-1:0] cr_q;
  logic [EXP_W-1:0] e_q;
  logic [EXP_W-1:0] dexp_q;
  logic sign_q;
  logic [SC_W-1:0] sc_q;
  logic exponent_carry_flag_q;
  logic zero_q;
  logic int_q;
  logic oor_q;
  logic [1:0] wi_q;
  fdr_mem_req_t mem_q;
  logic release_q;
  logic ap_valid_q;
  logic ap_write_q;
  logic [ADDR_W-1:0] ap_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  function automatic logic [WORD_W-1:0] result_word(input logic [1:0] idx, input logic sgn,
                                                    input logic [EXP_W-1:0] ex, input logic [FRAC_W-1:0] fr);
    logic [WORD_W-1:0] w;
    w = {sgn, ex, fr[46:40]};
    case (idx)
      2'h1: w = fr[39:24];
      2'h2: w = fr[23:8];
      2'h3: w = {fr[7:0], 8'h00};
      default: w = {sgn, ex, fr[46:40]};
    endcase
    return w;
  endfunction

  // Bus decode
  wire ap_take = hsel & hready & htrans[HTRANS_ACTIVE];
  wire dp_write = ap_valid_q & ap_write_q;
  wire wr_cmd = dp_write && (ap_addr_q == REG_CMD);
  wire wr_status = dp_write && (ap_addr_q == REG_STATUS);
  wire wr_acc_lo = dp_write && (ap_addr_q == REG_ACC_LO);
  wire wr_acc_hi = dp_write && (ap_addr_q == REG_ACC_HI);
  wire wr_addr = dp_write && (ap_addr_q == REG_MEM_ADDR);
  wire idle = (state_q == ST_IDLE) && !start_q;
  wire [1:0] cmd_code = hwdata[1:0];
  wire cmd_start = wr_cmd && idle && (cmd_code != OP_NONE);
  wire int_clear = wr_status && hwdata[ST_INT];

  wire [ADDR_W-1:0] rd_addr = haddr[ADDR_W-1:0];
  wire [31:0] status_word = {16'h0000, 3'h0, state_q, 3'h0, oor_q, int_q, zero_q, exponent_carry_flag_q, !idle};
  wire [31:0] acc_hi_word = {7'h00, sign_q, e_q, b_q[47:32]};
  wire [31:0] rd_mux = (rd_addr == REG_CMD) ? {30'h0, op_q} :
                       (rd_addr == REG_STATUS) ? status_word :
                       (rd_addr == REG_ACC_LO) ? b_q[31:0] :
                       (rd_addr == REG_ACC_HI) ? acc_hi_word :
                       (rd_addr == REG_MEM_ADDR) ? {16'h0000, mem_q.addr} :
                       (rd_addr == REG_MQ_LO) ? mq_q[31:0] :
                       (rd_addr == REG_MQ_HI) ? {16'h0000, mq_q[47:32]} : 32'h00000000;

  // Datapath
  // B plus constant
  wire [FRAC_W-1:0] round_sum = b_q + cr_q;
  wire sign_ovf = round_sum[FRAC_W-1];
  wire mem_free = !mem_q.req || mem_done;
  wire div_ge = (a_q >= b_q);
  wire [FRAC_W-1:0] div_rem = div_ge ? (a_q - b_q) : a_q;
  wire quot_mode = (state_q == ST_DIV_EXPONENT);
  wire [EXP_W-1:0] exp_sum;
  wire exp_carry;
  wire [1:0] word_sel = (state_q == ST_STORE_SECOND_WORD) ? 2'h1 :
                        (state_q == ST_STORE_THIRD_WORD) ? 2'h2 :
                        (state_q == ST_STORE_FOURTH_WORD) ? 2'h3 : 2'h0;
  wire [WORD_W-1:0] word_out = result_word(word_sel, sign_q, e_q, round_sum);

  fdr_exp_alu u_exp_alu (
    .exp_a(e_q),
    .exp_b(dexp_q),
    .quot_mode(quot_mode),
    .exp_sum(exp_sum),
    .exp_carry(exp_carry)
  );

  // Bus slave: read data registered from the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= REG_CMD;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      ap_valid_q <= ap_take;
      ap_write_q <= hwrite;
      ap_addr_q <= rd_addr;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (ap_take && !hwrite)
        hrdata_q <= rd_mux;
    end
  end

  // Interrupt flag: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_q <= 1'b0;
    else if ((state_q == ST_OVF_TERM) || (state_q == ST_STORE_EXP_OVF))
      int_q <= 1'b1;
    else if (int_clear)
      int_q <= 1'b0;
  end

  // Instruction latch and start pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_q <= OP_NONE;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= cmd_start;
      if (cmd_start)
        op_q <= fdr_op_t'(cmd_code);
    end
  end

  // Main sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_IDLE;
      a_q <= FRAC_ZERO;
      b_q <= FRAC_ZERO;
      mq_q <= FRAC_ZERO;
      cr_q <= FRAC_ZERO;
      e_q <= EXP_ZERO;
      dexp_q <= EXP_ZERO;
      sign_q <= 1'b0;
      sc_q <= '0;
      exponent_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
      oor_q <= 1'b0;
      wi_q <= 2'h0;
      mem_q <= '0;
      release_q <= 1'b0;
    end
    else
    begin
      release_q <= 1'b0;
      if (mem_done)
        mem_q.req <= 1'b0;
      mem_q.wdata <= word_out;
      if (wr_acc_lo && idle)
      begin
        a_q[31:0] <= hwdata;
        b_q[31:0] <= hwdata;
      end
      if (wr_acc_hi && idle)
      begin
        a_q[47:32] <= hwdata[15:0];
        b_q[47:32] <= hwdata[15:0];
        e_q <= hwdata[ACC_HI_EXP_LSB +: EXP_W];
        sign_q <= hwdata[ACC_HI_SIGN];
      end
      if (wr_addr && idle)
        mem_q.addr <= hwdata[WORD_W-1:0];
      if (cmd_start && (cmd_code == OP_STORE_SINGLE))
        cr_q <= CR_ROUND_SINGLE;
      if (cmd_start && (cmd_code == OP_STORE_DOUBLE))
        cr_q <= CR_ROUND_DOUBLE;
      case (state_q)
        ST_IDLE:
        begin
          if (start_q && (op_q == OP_DIV_DOUBLE))
          begin
            mem_q.req <= 1'b1;
            mem_q.write <= 1'b0;
            wi_q <= 2'h0;
            state_q <= ST_DIV_FETCH;
          end
          else if (start_q)
            state_q <= ST_STORE_FIRST;
        end
        ST_DIV_FETCH:
        begin
          if (mem_done)
          begin
            mq_q <= mq_q;
            if (wi_q == 2'h0)
            begin
              dexp_q <= mem_rdata[14:7];
              mq_q[46:40] <= mem_rdata[6:0];
            end
            else if (wi_q == 2'h1)
              mq_q[39:24] <= mem_rdata;
            else
              mq_q[23:8] <= mem_rdata;
            mem_q.addr <= mem_q.addr + 16'h0001;
            wi_q <= wi_q + 2'h1;
            if (wi_q == WORD_IDX_THIRD)
              state_q <= ST_DIV_EXPONENT;
            else
              mem_q.req <= 1'b1;
          end
        end
        ST_DIV_EXPONENT:
        begin
          e_q <= exp_sum;
          exponent_carry_flag_q <= exp_carry;
          mem_q.req <= 1'b1;
          state_q <= ST_DIV_RANGE;
        end
        ST_DIV_RANGE:
        begin
          oor_q <= exponent_carry_flag_q;
          state_q <= ST_DIV_FINAL_LOAD;
        end
        ST_DIV_FINAL_LOAD:
        begin
          if (mem_done)
          begin
            mq_q[7:0] <= mem_rdata[15:8];
            mq_q[47] <= 1'b0;
            mem_q.addr <= mem_q.addr + 16'h0001;
            if (a_q == FRAC_ZERO)
              state_q <= ST_DIV_ZERO_CHECK;
            else
              state_q <= ST_DIV_COUNT_PRESET;
          end
        end
        ST_DIV_ZERO_CHECK:
        begin
          b_q <= mq_q;
          state_q <= ST_DIV_ZERO_TEST;
        end
        ST_DIV_ZERO_TEST:
        begin
          zero_q <= (b_q == FRAC_ZERO);
          if (b_q == FRAC_ZERO)
            state_q <= ST_OVF_TERM;
          else
          begin
            a_q <= FRAC_ZERO;
            b_q <= FRAC_ZERO;
            e_q <= EXP_ZERO;
            state_q <= ST_IDLE;
          end
        end
        ST_DIV_COUNT_PRESET:
        begin
          sc_q <= DIV_BITS_DOUBLE;
          b_q <= mq_q;
          mq_q <= FRAC_ZERO;
          state_q <= oor_q ? ST_DIV_ITER_OOR : ST_DIV_ITER;
        end
        ST_DIV_ITER, ST_DIV_ITER_OOR:
        begin
          mq_q <= {mq_q[FRAC_W-2:0], div_ge};
          a_q <= {div_rem[FRAC_W-2:0], 1'b0};
          sc_q <= sc_q - SC_LAST;
          exponent_carry_flag_q <= exp_carry;
          if (sc_q == SC_LAST)
            state_q <= ST_DIV_COPY;
        end
        ST_DIV_COPY:
        begin
          a_q <= mq_q;
          b_q <= mq_q;
          state_q <= ST_IDLE;
        end
        ST_OVF_TERM:
        begin
          a_q <= FRAC_ONES;
          b_q <= FRAC_ONES;
          e_q <= EXP_MAX;
          state_q <= ST_IDLE;
        end
        ST_STORE_FIRST:
        begin
          a_q <= round_sum;
          zero_q <= 1'b0;
          mem_q.req <= 1'b1;
          mem_q.write <= 1'b1;
          state_q <= ST_STORE_SECOND;
        end
        ST_STORE_SECOND:
        begin
          a_q <= round_sum;
          exponent_carry_flag_q <= exp_carry;
          state_q <= sign_ovf ? ST_STORE_ROUND_OVF : ST_STORE_FIRST_FINISH;
        end
        ST_STORE_ROUND_OVF:
        begin
          if (mem_free)
          begin
            a_q <= round_sum;
            b_q <= round_sum;
            cr_q <= CR_SIGN_BIT;
            state_q <= exponent_carry_flag_q ? ST_STORE_EXP_OVF : ST_STORE_RENORM;
          end
        end
        ST_STORE_RENORM:
        begin
          a_q <= {1'b0, a_q[FRAC_W-1:1]};
          b_q <= {1'b0, b_q[FRAC_W-1:1]};
          e_q <= exp_sum;
          cr_q <= FRAC_ZERO;
          state_q <= ST_STORE_FIRST;
        end
        ST_STORE_EXP_OVF:
        begin
          b_q <= ~cr_q;
          e_q <= EXP_MAX;
          state_q <= ST_STORE_CONST_CLEAR;
        end
        ST_STORE_CONST_CLEAR:
        begin
          cr_q <= FRAC_ZERO;
          state_q <= ST_STORE_FIRST;
        end
        ST_STORE_FIRST_FINISH:
        begin
          if (mem_free)
          begin
            mem_q.addr <= mem_q.addr + 16'h0001;
            mem_q.req <= 1'b1;
            // Next word stands with its request
            mem_q.wdata <= result_word(2'h1, sign_q, e_q, round_sum);
            state_q <= ST_STORE_SECOND_WORD;
          end
        end
        ST_STORE_SECOND_WORD:
        begin
          a_q <= round_sum;
          if (mem_done)
          begin
            if (op_q == OP_STORE_DOUBLE)
            begin
              mem_q.addr <= mem_q.addr + 16'h0001;
              mem_q.req <= 1'b1;
              mem_q.wdata <= result_word(2'h2, sign_q, e_q, round_sum);
              state_q <= ST_STORE_THIRD_WORD;
            end
            else
            begin
              release_q <= 1'b1;
              state_q <= ST_STORE_FINAL;
            end
          end
        end
        ST_STORE_THIRD_WORD:
        begin
          if (mem_done)
          begin
            mem_q.addr <= mem_q.addr + 16'h0001;
            mem_q.req <= 1'b1;
            mem_q.wdata <= result_word(2'h3, sign_q, e_q, round_sum);
            state_q <= ST_STORE_FOURTH_WORD;
          end
        end
        ST_STORE_FOURTH_WORD:
        begin
          if (mem_done)
          begin
            release_q <= 1'b1;
            state_q <= ST_STORE_FINAL;
          end
        end
        ST_STORE_FINAL:
        begin
          // Rounded fraction into A and B
          a_q <= round_sum;
          b_q <= round_sum;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign mem_out = mem_q;
  assign cpu_release = release_q;
  assign interrupt_flag = int_q;

endmodule

// file: fdr_core_assertions.sv
/* Checker on the fdr_core ports: memory handshake, address steps,
   release pulse, interrupt clear and command start. One clock, hclk. */
`timescale 1ns/10ps
module fdr_core_assertions
  import fdr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire fdr_mem_req_t mem_out,
  input wire logic mem_done,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic cpu_release,
  input wire logic interrupt_flag
);
  wire logic wr_ap = hsel && hready && htrans[1] && hwrite;
  logic st_wr_q;
  logic cmd_wr_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_wr_q <= 1'b0;
      cmd_wr_q <= 1'b0;
    end
    else
    begin
      st_wr_q <= wr_ap && haddr[7:0] == REG_STATUS;
      cmd_wr_q <= wr_ap && haddr[7:0] == REG_CMD;
    end
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_req_held:
    assert property (mem_out.req && !mem_done |=> mem_out.req) else $error("request dropped before done");
  a_req_stable:
    assert property (mem_out.req && !mem_done |=> $stable(mem_out.addr) && $stable(mem_out.write))
      else $error("request changed while waiting");
  a_addr_step:
    assert property (mem_done && mem_out.req ##1 mem_out.req |-> mem_out.addr == $past(mem_out.addr) + 16'h0001)
      else $error("chained request without address step");
  a_release_pulse:
    assert property (cpu_release |=> !cpu_release) else $error("release longer than one cycle");
  a_release_cause:
    assert property (cpu_release |-> $past(mem_done) && $past(mem_out.write)) else $error("release without write done");
  a_int_clear:
    assert property ($fell(interrupt_flag) |-> $past(st_wr_q) && $past(hwdata[3])) else $error("interrupt fell unasked");
  a_store_start:
    assert property (cmd_wr_q && hwdata[1] |-> ##[1:6] mem_out.req && mem_out.write) else $error("store not started");
  a_div_start:
    assert property (cmd_wr_q && hwdata[1:0] == 2'h1 |-> ##[1:6] mem_out.req && !mem_out.write)
      else $error("divisor fetch not started");
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus wait or error");
  c_release: cover property (cpu_release);
  c_int: cover property ($rose(interrupt_flag));
  c_read: cover property (mem_done && mem_out.req && !mem_out.write);
endmodule
bind fdr_core fdr_core_assertions fdr_core_assertions_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .mem_out, .mem_done, .mem_rdata, .cpu_release,
  .interrupt_flag);

// file: fdr_mem_model.sv
/* Memory side model: answers each request after a set delay.
   Assumes one request at a time, held until done. */
`timescale 1ns/10ps
module fdr_mem_model
  import fdr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire fdr_mem_req_t mem_out,
  input wire logic [3:0] delay,
  output logic mem_done,
  output logic [WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] mem [0:255];
  logic [WORD_W-1:0] rd_log [0:255];
  logic [3:0] cnt_q;
  int n_wr = 0;
  int n_rd = 0;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_done <= 1'b0;
      mem_rdata <= 16'h0000;
      cnt_q <= 4'h0;
    end
    else if (mem_done)
    begin
      mem_done <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_q <= 4'h0;
    end
    else if (mem_out.req && cnt_q != delay)
      cnt_q <= cnt_q + 4'h1;
    else if (mem_out.req)
    begin
      mem_done <= 1'b1;
      if (mem_out.write)
      begin
        mem[mem_out.addr[7:0]] <= mem_out.wdata;
        n_wr <= n_wr + 1;
      end
      else
      begin
        mem_rdata <= mem[mem_out.addr[7:0]];
        rd_log[n_rd[7:0]] <= mem_out.addr;
        n_rd <= n_rd + 1;
      end
    end
  end
endmodule

// file: tb.sv
/* Testbench of fdr_core: stores, overflows and double divide.
   Assumes fdr_mem_model on the memory port. */
`timescale 1ns/10ps
module tb
  import fdr_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] delay = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  fdr_mem_req_t mem_out;
  logic mem_done;
  logic [WORD_W-1:0] mem_rdata;
  logic cpu_release;
  logic interrupt_flag;
  int n_fail = 0;
  int n_compared = 0;
  int n_rel = 0;
  int cyc = 0;
  fdr_core fdr_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .mem_out, .mem_done, .mem_rdata, .cpu_release, .interrupt_flag);
  fdr_mem_model fdr_mem_model_i (.hclk, .hresetn, .mem_out, .delay, .mem_done, .mem_rdata);
  always #5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cpu_release === 1'b1) n_rel++;
  end
  task end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task run(input logic [1:0] op, input logic [47:0] f, input logic [7:0] e, input logic [7:0] b);
    logic [31:0] s;
    wr(REG_ACC_LO, f[31:0]);
    wr(REG_ACC_HI, {8'h00, e, f[47:32]});
    wr(REG_MEM_ADDR, {24'h0, b});
    wr(REG_CMD, {30'h0, op});
    s = 32'h1;
    for (int i = 0; i < 300 && s[0] !== 1'b0; i++) rd(REG_STATUS, s);
    chk("busy", 48'h0, s[0]);
  endtask
  task store(input logic [1:0] op, input logic [47:0] f, input logic [7:0] e, input logic [7:0] b,
    input logic [47:0] rf, input logic [7:0] re, input int nwr);
    logic [15:0] w [4];
    int w0;
    int r0;
    w0 = fdr_mem_model_i.n_wr;
    r0 = n_rel;
    run(op, f, e, b);
    w = '{{1'b0, re, rf[46:40]}, rf[39:24], rf[23:8], {rf[7:0], 8'h00}};
    for (int i = 0; i < (op == 2'h3 ? 4 : 2); i++) chk("mem word", w[i], fdr_mem_model_i.mem[b + i]);
    chk("writes", nwr, fdr_mem_model_i.n_wr - w0);
    chk("releases", 1, n_rel - r0);
  endtask
  task div(input logic [47:0] f, input logic [7:0] b, input logic [15:0] w1, output int span);
    int r0;
    int t0;
    delay <= 4'h2;
    fdr_mem_model_i.mem[b] = w1;
    for (int i = 1; i < 4; i++) fdr_mem_model_i.mem[b + i] = 16'h0000;
    r0 = fdr_mem_model_i.n_rd;
    t0 = cyc;
    run(2'h1, f, 8'h81, b);
    span = cyc - t0;
    chk("reads", 4, fdr_mem_model_i.n_rd - r0);
    for (int i = 0; i < 4; i++) chk("read addr", b + i, fdr_mem_model_i.rd_log[r0 + i]);
  endtask
  task clear_int;
    wr(REG_STATUS, 32'h8);
    @(negedge hclk);
    chk("int cleared", 48'h0, interrupt_flag);
  endtask
  task t_reset;
    logic [31:0] d;
    @(negedge hclk);
    chk("mem_out", 48'h0, mem_out);
    chk("release", 48'h0, cpu_release);
    chk("int", 48'h0, interrupt_flag);
    rd(REG_STATUS, d);
    chk("status", 48'h0, d[4:0]);
    rd(8'h3C, d);
    chk("unmapped", 48'h0, d);
  endtask
  task t_single;
    logic [31:0] d;
    delay <= 4'h3;
    store(2'h2, 48'h4123457FFFFF, 8'h81, 8'h20, 48'h4123467FFFFF, 8'h81, 2);
    rd(REG_ACC_LO, d);
    chk("rounded acc", 48'h467FFFFF, d);
  endtask
  task t_double;
    delay <= 4'h0;
    store(2'h3, 48'h6000000000FF, 8'h90, 8'h40, 48'h600000000101, 8'h90, 4);
  endtask
  task t_frac_ovf;
    delay <= 4'h2;
    store(2'h2, 48'h7FFFFFFF0000, 8'h85, 8'h50, 48'h4000007F8000, 8'h86, 3);
    chk("int", 48'h0, interrupt_flag);
  endtask
  task t_exp_ovf;
    delay <= 4'h1;
    store(2'h2, 48'h7FFFFFFF0000, 8'hFF, 8'h58, 48'h7FFFFFFFFFFF, 8'hFF, 3);
    chk("int", 48'h1, interrupt_flag);
    clear_int;
  endtask
  task t_div_zero;
    logic [31:0] d;
    int s;
    div(48'h0, 8'h60, 16'h4000, s);
    rd(REG_ACC_LO, d);
    chk("ovf frac", 48'hFFFFFFFF, d);
    rd(REG_ACC_HI, d);
    chk("ovf exp frac", 48'hFFFFFF, d[23:0]);
    chk("int", 48'h1, interrupt_flag);
    rd(REG_STATUS, d);
    chk("zero status", 48'hC, d[4:0]);
    clear_int;
  endtask
  task t_div_norm;
    logic [31:0] d;
    int s;
    div(48'h200000000000, 8'h68, 16'h40C0, s);
    chk("div span", 48'h1, s >= 60);
    rd(REG_ACC_HI, d);
    chk("quotient", 48'h804000, d[23:0]);
    chk("int", 48'h0, interrupt_flag);
  endtask
  initial
  begin
    #600000;
    n_fail++;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_single;
    t_double;
    t_frac_ovf;
    t_exp_ovf;
    t_div_zero;
    t_div_norm;
    end_sim;
  end
endmodule
